// >>> logic/debug_access_ctrl.sv
// Background debug access controller: command gating, security, background mode.
// Assumes APB master on pclk; core-side inputs synchronous to pclk.
// Operation
// - Secured reset clears unsecured flag
// - Secured: only control register and erase; the code also accepts sync and handshake enable/disable
// - Erase success unsecures; failure stays secured
// - Background mode needs debug enable bit, except entry by single-chip reset
// - Enter via halt, instruction, breakpoint, single-chip reset
// - First command accepted 10 cycles after reset
// - During NVM init only always-available run
// - Only debug commands change CPU while halted
// - Halt while disabled ignored, no CPU delay
// - Clock select routes serial clock source
// - Internal accesses use core clock
// - Always-available commands accepted in any state
// - Non-intrusive need enable and unsecured
// - Active commands need unsecured and halted
// - Active: CPU registers, step, resume
// - Non-intrusive also accepted while halted
// - No handshake: steal next bus cycle
// - Illegal command sets flag, reads 0xEE bytes
// - Handshake, no steal: 512-cycle timeout aborts
// - Command code is eight bits
`timescale 1ns/1ns
module debug_access_ctrl
  import debug_access_pkg::*;
#(
  parameter int TIMEOUT = NO_RESPONSE_FLAG_CYCLES
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [debug_access_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Device straps and status
  input  wire logic                        secure_strap,
  input  wire logic                        ssc_strap,
  input  wire logic                        nvm_init_busy,
  // CPU side
  input  wire logic                        halt_insn,
  input  wire logic                        breakpoint_hit,
  input  wire logic [31:0]                 cpu_reg_rdata,
  output logic                             cpu_halt,
  output logic                             cpu_step,
  output logic                             cpu_reg_we,
  output logic [3:0]                       cpu_reg_num,
  output logic [31:0]                      cpu_reg_wdata,
  // System bus side
  input  wire logic                        bus_free,
  input  wire logic [31:0]                 bus_rdata,
  output debug_access_pkg::bus_req_s       bus_req,
  output logic                             bus_steal,
  // Flash mass erase
  input  wire logic                        erase_done,
  input  wire logic                        erase_ok,
  output logic                             erase_req,
  output logic                             unsecured_flag_program,
  // Link side indications
  output logic                             clk_sel,
  output logic                             ack_pulse,
  output logic                             ack_long,
  output logic                             sync_pulse
);
  import debug_access_pkg::*;

  localparam int TW = $clog2(TIMEOUT + 1);

  ctrl_state_e state_q;
  ctrl_state_e state_d;
  cmd_class_e  cls;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0]  rdy_cnt_q;
  logic        ready_q;
  logic        init_q;
  logic        unsecured_flag_q;
  logic        en_q;
  logic        bdm_q;
  logic        steal_q;
  logic        clksel_q;
  logic        ackon_q;
  logic        no_response_flag_q;
  logic        illegal_command_flag_q;
  logic [TW-1:0] tmo_q;
  logic        legal;
  logic        steal_mode;
  logic        wr_acc;
  logic        rd_acc;
  logic        cmd_wr;
  logic        stall;
  logic        ev_ill;
  logic        ev_no_response_flag;
  logic        ev_halt;
  logic        ev_resume;
  logic        ev_csr_wr;
  logic        ev_unsecured_flag;
  logic        ev_ackon;
  logic        ev_ackoff;
  logic        ev_ack;
  logic        ev_ack_long;
  logic        ev_sync;
  logic        ev_step;
  logic        ev_reg_we;
  logic        ev_bus_start;
  logic        ev_erase_start;
  logic        rdata_we;
  logic [31:0] csr_val;

  assign csr_val = {23'h000000, (state_q == ST_ERASE), unsecured_flag_q, en_q, bdm_q, steal_q,
                    clksel_q, ackon_q, no_response_flag_q, illegal_command_flag_q};
  assign wr_acc  = psel & penable & pwrite & ~pready;
  assign rd_acc  = psel & penable & ~pwrite & ~pready;
  assign cmd_wr  = wr_acc & (paddr == OFF_CMD);
  // Command waits until the controller is ready and idle
  assign stall   = cmd_wr & (~ready_q | (state_q != ST_IDLE));
  assign steal_mode = ~ackon_q | steal_q;

  // Command classes
  always_comb begin
    case (op_q)
      OP_CSR_RD, OP_CSR_WR, OP_ERASE, OP_SYNC, OP_ACK_EN, OP_ACK_DIS: cls = CLS_ALWAYS;
      OP_MEM_RD, OP_MEM_WR, OP_NOP, OP_HALT:                           cls = CLS_NONINT;
      OP_REG_RD, OP_REG_WR, OP_STEP, OP_RESUME:                         cls = CLS_ACTIVE;
      default:                                                          cls = CLS_NONE;
    endcase
  end

  // Gating; an erase in progress stalls every command, always-available included, until idle
  always_comb begin
    case (cls)
      CLS_ALWAYS: legal = 1'b1;
      CLS_NONINT: legal = en_q & unsecured_flag_q;
      CLS_ACTIVE: legal = unsecured_flag_q & bdm_q;
      default:    legal = 1'b0;
    endcase
  end

  // Command sequencer and its events
  always_comb begin
    state_d        = state_q;
    rdata_d        = rdata_q;
    rdata_we       = 1'b0;
    ev_ill         = 1'b0;
    ev_no_response_flag      = 1'b0;
    ev_halt        = 1'b0;
    ev_resume      = 1'b0;
    ev_csr_wr      = 1'b0;
    ev_unsecured_flag       = 1'b0;
    ev_ackon       = 1'b0;
    ev_ackoff      = 1'b0;
    ev_ack         = 1'b0;
    ev_ack_long    = 1'b0;
    ev_sync        = 1'b0;
    ev_step        = 1'b0;
    ev_reg_we      = 1'b0;
    ev_bus_start   = 1'b0;
    ev_erase_start = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_wr && !stall) begin
          state_d = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (cls != CLS_ALWAYS && nvm_init_busy) begin
          state_d = ST_DECODE;
        end else if (!legal) begin
          state_d  = ST_IDLE;
          ev_ill   = 1'b1;
          rdata_d  = ILLEGAL_DATA;
          rdata_we = 1'b1;
        end else begin
          state_d = ST_IDLE;
          case (op_q)
            OP_CSR_RD: begin
              rdata_d  = csr_val;
              rdata_we = 1'b1;
            end
            OP_CSR_WR:  ev_csr_wr = 1'b1;
            OP_ACK_EN: begin
              ev_ackon = 1'b1;
              ev_ack   = 1'b1;
            end
            OP_ACK_DIS: ev_ackoff = 1'b1;
            OP_SYNC:    ev_sync = 1'b1;
            OP_ERASE: begin
              ev_erase_start = 1'b1;
              state_d        = ST_ERASE;
            end
            OP_HALT: begin
              ev_halt = 1'b1;
              ev_ack  = 1'b1;
            end
            OP_MEM_RD, OP_MEM_WR: begin
              ev_bus_start = 1'b1;
              state_d      = ST_BUS;
            end
            OP_REG_RD: begin
              rdata_d  = cpu_reg_rdata;
              rdata_we = 1'b1;
              ev_ack   = 1'b1;
            end
            OP_REG_WR: begin
              ev_reg_we = 1'b1;
              ev_ack    = 1'b1;
            end
            OP_STEP: begin
              ev_step = 1'b1;
              ev_ack  = 1'b1;
            end
            OP_RESUME: begin
              ev_resume = 1'b1;
              ev_ack    = 1'b1;
            end
            default:    ev_ack = 1'b1;
          endcase
        end
      end
      ST_BUS: begin
        if (bus_free) begin
          state_d = ST_IDLE;
          ev_ack  = 1'b1;
          if (!bus_req.we) begin
            rdata_d  = bus_rdata;
            rdata_we = 1'b1;
          end
        end else if (!steal_mode && tmo_q == TW'(TIMEOUT - 1)) begin
          state_d     = ST_IDLE;
          ev_no_response_flag   = 1'b1;
          ev_ack_long = 1'b1;
          rdata_d     = ILLEGAL_DATA;
          rdata_we    = 1'b1;
        end
      end
      ST_ERASE: begin
        if (erase_done) begin
          state_d  = ST_IDLE;
          ev_unsecured_flag = erase_ok;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      rdata_q <= ZERO32;
    end else begin
      state_q <= state_d;
      if (rdata_we) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Readiness after reset, and strap capture one edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_cnt_q <= 4'h0;
      ready_q   <= 1'b0;
      init_q    <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (rdy_cnt_q != 4'(READY_CYCLES)) begin
        rdy_cnt_q <= rdy_cnt_q + 4'h1;
      end
      ready_q <= (rdy_cnt_q == 4'(READY_CYCLES - 1)) | ready_q;
    end
  end

  // Security state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unsecured_flag_q       <= 1'b0;
      unsecured_flag_program <= 1'b0;
    end else begin
      unsecured_flag_program <= ev_unsecured_flag;
      if (!init_q) begin
        unsecured_flag_q <= ~secure_strap;
      end else if (ev_unsecured_flag) begin
        unsecured_flag_q <= 1'b1;
      end
    end
  end

  // Control bits and sticky flags; a new event wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q     <= 1'b0;
      steal_q  <= 1'b0;
      clksel_q <= 1'b0;
      ackon_q  <= 1'b0;
      no_response_flag_q <= 1'b0;
      illegal_command_flag_q <= 1'b0;
    end else begin
      if (ev_csr_wr) begin
        en_q     <= wdata_q[B_ENABLE];
        steal_q  <= wdata_q[B_STEAL];
        clksel_q <= wdata_q[B_CLKSEL];
      end
      ackon_q  <= ev_ackon | (ackon_q & ~ev_ackoff);
      no_response_flag_q <= ev_no_response_flag | (no_response_flag_q & ~(ev_csr_wr & wdata_q[B_NO_RESPONSE_FLAG]));
      illegal_command_flag_q <= ev_ill | (illegal_command_flag_q & ~(ev_csr_wr & wdata_q[B_ILLEGAL_COMMAND_FLAG]));
    end
  end

  // Background mode; the CPU completes its current instruction before halting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bdm_q <= 1'b0;
    end else if (!init_q) begin
      bdm_q <= ssc_strap;
    end else if (ev_halt || (en_q && (halt_insn || breakpoint_hit))) begin
      bdm_q <= 1'b1;
    end else if (ev_resume) begin
      bdm_q <= 1'b0;
    end
  end

  // Bus access with cycle stealing or bounded wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_req   <= '0;
      bus_steal <= 1'b0;
      tmo_q     <= '0;
    end else begin
      if (ev_bus_start) begin
        bus_req.req   <= 1'b1;
        bus_req.we    <= (op_q == OP_MEM_WR);
        bus_req.addr  <= addr_q;
        bus_req.wdata <= wdata_q;
        bus_steal     <= steal_mode;
        tmo_q         <= '0;
      end else if (state_q == ST_BUS && state_d != ST_BUS) begin
        bus_req.req <= 1'b0;
        bus_steal   <= 1'b0;
      end else if (state_q == ST_BUS) begin
        tmo_q <= tmo_q + TW'(1);
      end
    end
  end

  // CPU, erase and link strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_step      <= 1'b0;
      cpu_reg_we    <= 1'b0;
      cpu_reg_num   <= 4'h0;
      cpu_reg_wdata <= ZERO32;
      erase_req     <= 1'b0;
      ack_pulse     <= 1'b0;
      ack_long      <= 1'b0;
      sync_pulse    <= 1'b0;
    end else begin
      cpu_step      <= ev_step;
      cpu_reg_we    <= ev_reg_we;
      cpu_reg_num   <= addr_q[3:0];
      cpu_reg_wdata <= wdata_q;
      erase_req     <= ev_erase_start | (erase_req & ~erase_done);
      // Handshake pulses only when the host turned the handshake on
      ack_pulse     <= ev_ack & (ackon_q | ev_ackon);
      ack_long      <= ev_ack_long;
      sync_pulse    <= ev_sync;
    end
  end

  assign cpu_halt = bdm_q;
  assign clk_sel  = clksel_q;

  // APB registers and answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q    <= OP_NOP;
      addr_q  <= 24'h000000;
      wdata_q <= ZERO32;
      prdata  <= ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= (wr_acc & ~stall) | rd_acc;
      pslverr <= 1'b0;
      prdata  <= ZERO32;
      if (wr_acc && !stall) begin
        case (paddr)
          OFF_ADDR:  addr_q  <= pwdata[23:0];
          OFF_WDATA: wdata_q <= pwdata;
          OFF_CMD:   op_q    <= pwdata[7:0];
          default:   pslverr <= 1'b1;
        endcase
      end
      if (rd_acc) begin
        case (paddr)
          OFF_CSR:   prdata <= csr_val;
          OFF_ADDR:  prdata <= {8'h00, addr_q};
          OFF_WDATA: prdata <= wdata_q;
          OFF_CMD:   prdata <= {22'h000000, ready_q, (state_q != ST_IDLE), op_q};
          OFF_RDATA: prdata <= rdata_q;
          default:   pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // debug_access_ctrl

// >>> logic/debug_access_pkg.sv
// Constants, types and register map of the background debug access controller.
// Assumes an APB master with 32-bit data and word-aligned register offsets.
package debug_access_pkg;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_CSR       = 8'h00;
  localparam logic [7:0]  OFF_ADDR      = 8'h04;
  localparam logic [7:0]  OFF_WDATA     = 8'h08;
  localparam logic [7:0]  OFF_CMD       = 8'h0C;
  localparam logic [7:0]  OFF_RDATA     = 8'h10;
  // Control and status bit positions
  localparam int          B_ILLEGAL_COMMAND_FLAG      = 0;
  localparam int          B_NO_RESPONSE_FLAG      = 1;
  localparam int          B_ACKON       = 2;
  localparam int          B_CLKSEL      = 3;
  localparam int          B_STEAL       = 4;
  localparam int          B_BGACT       = 5;
  localparam int          B_ENABLE      = 6;
  localparam int          B_UNSECURED_FLAG       = 7;
  localparam int          B_ERASING     = 8;
  localparam int          B_BUSY        = 8;
  localparam int          B_READY       = 9;
  // Command codes
  localparam logic [7:0]  OP_NOP        = 8'h00;
  localparam logic [7:0]  OP_ACK_EN     = 8'h02;
  localparam logic [7:0]  OP_ACK_DIS    = 8'h03;
  localparam logic [7:0]  OP_HALT       = 8'h04;
  localparam logic [7:0]  OP_RESUME     = 8'h08;
  localparam logic [7:0]  OP_STEP       = 8'h09;
  localparam logic [7:0]  OP_CSR_WR     = 8'h0D;
  localparam logic [7:0]  OP_MEM_WR     = 8'h10;
  localparam logic [7:0]  OP_CSR_RD     = 8'h2D;
  localparam logic [7:0]  OP_MEM_RD     = 8'h30;
  localparam logic [7:0]  OP_REG_WR     = 8'h40;
  localparam logic [7:0]  OP_REG_RD     = 8'h60;
  localparam logic [7:0]  OP_ERASE      = 8'h95;
  localparam logic [7:0]  OP_SYNC       = 8'hFF;
  // Timing and data constants
  localparam int          READY_CYCLES  = 10;
  localparam int          NO_RESPONSE_FLAG_CYCLES = 512;
  localparam logic [31:0] ILLEGAL_DATA  = 32'hEEEEEEEE;
  localparam logic [31:0] ZERO32        = 32'h00000000;

  typedef enum logic [1:0] {
    CLS_ALWAYS = 2'b00,
    CLS_NONINT = 2'b01,
    CLS_ACTIVE = 2'b10,
    CLS_NONE   = 2'b11
  } cmd_class_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DECODE = 2'b01,
    ST_BUS    = 2'b10,
    ST_ERASE  = 2'b11
  } ctrl_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [23:0] addr;
    logic [31:0] wdata;
  } bus_req_s;
endpackage

// >>> tb/core_side_model.sv
// Core side model: system bus, flash erase engine and CPU register file.
// Assumes controller requests on pclk; slow keeps the bus busy forever.
`timescale 1ns/1ns
module core_side_model
  import debug_access_pkg::*;
(
  // Clock, reset and bench controls
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       slow,
  input wire logic                       erase_pass,
  // Controller requests
  input wire debug_access_pkg::bus_req_s bus_req,
  input wire logic                       erase_req,
  input wire logic                       cpu_reg_we,
  input wire logic [3:0]                 cpu_reg_num,
  input wire logic [31:0]                cpu_reg_wdata,
  // Answers
  output logic                           bus_free,
  output logic [31:0]                    bus_rdata,
  output logic                           erase_done,
  output logic                           erase_ok,
  output logic [31:0]                    cpu_reg_rdata
);
  logic [2:0]  cnt_q;
  logic [2:0]  ecnt_q;
  logic [31:0] regs_q [16];
  // Free cycle after three busy ones; data toggles when not valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      bus_free <= 1'b0;
      bus_rdata <= 32'h00000000;
    end else begin
      cnt_q <= (bus_req.req && !bus_free) ? cnt_q + 3'h1 : 3'h0;
      bus_free <= bus_req.req && !bus_free && !slow && cnt_q == 3'h2;
      bus_rdata <= (cnt_q == 3'h2) ? {8'h5A, bus_req.addr} : ~bus_rdata;
    end
  end
  // Erase engine answers after a few cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecnt_q <= 3'h0;
      erase_done <= 1'b0;
      erase_ok <= 1'b0;
    end else begin
      ecnt_q <= (erase_req && !erase_done) ? ecnt_q + 3'h1 : 3'h0;
      erase_done <= erase_req && !erase_done && ecnt_q == 3'h4;
      erase_ok <= (ecnt_q == 3'h4) ? erase_pass : ~erase_ok;
    end
  end
  // Only debug writes touch the registers
  always_ff @(posedge pclk) begin
    if (cpu_reg_we) regs_q[cpu_reg_num] <= cpu_reg_wdata;
  end
  assign cpu_reg_rdata = regs_q[cpu_reg_num];
endmodule // core_side_model

// >>> tb/debug_access_asserts.sv
// Port checker for the background debug access controller.
// Assumes one pclk domain; bound into every debug_access_ctrl instance.
`timescale 1ns/1ns
module debug_access_asserts
  import debug_access_pkg::*;
#(
  parameter int TIMEOUT = NO_RESPONSE_FLAG_CYCLES
) (
  // Clock and reset
  input wire logic                            pclk,
  input wire logic                            presetn,
  // APB
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [debug_access_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  // Core side
  input wire logic                            cpu_halt,
  input wire logic                            cpu_reg_we,
  input wire logic                            bus_free,
  input wire debug_access_pkg::bus_req_s      bus_req,
  input wire logic                            bus_steal,
  input wire logic                            erase_req,
  input wire logic                            erase_done,
  input wire logic                            erase_ok,
  input wire logic                            unsecured_flag_program
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] rst_cnt_q;
  logic [9:0] wait_q;
  // Edges since reset release, and cycles a non-stealing access has waited
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_q <= 4'h0;
      wait_q <= 10'h000;
    end else begin
      if (rst_cnt_q != 4'hF) rst_cnt_q <= rst_cnt_q + 4'h1;
      wait_q <= (bus_req.req && !bus_steal && !bus_free) ? wait_q + 10'h001 : 10'h000;
    end
  end
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_unmapped; (psel && penable && pready && paddr > OFF_RDATA) |-> pslverr; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access without error");
  property p_prdata_idle; !pready |-> prdata == ZERO32; endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside answer");
  property p_cmd_ready;
    (psel && penable && pwrite && pready && paddr == OFF_CMD) |-> rst_cnt_q >= READY_CYCLES;
  endproperty
  a_cmd_ready: assert property (p_cmd_ready) else $error("command taken too early");
  property p_req_bounded; wait_q <= TIMEOUT + 2; endproperty
  a_req_bounded: assert property (p_req_bounded) else $error("access not aborted");
  property p_req_done; bus_req.req && bus_free |=> !bus_req.req; endproperty
  a_req_done: assert property (p_req_done) else $error("request held after free cycle");
  property p_steal_req; bus_steal |-> bus_req.req; endproperty
  a_steal_req: assert property (p_steal_req) else $error("steal without request");
  property p_erase_ok; (erase_req && erase_done && erase_ok) |-> ##[0:2] unsecured_flag_program; endproperty
  a_erase_ok: assert property (p_erase_ok) else $error("no unsecure after erase");
  property p_erase_fail;
    (erase_req && erase_done && !erase_ok) |=> !unsecured_flag_program [*3];
  endproperty
  a_erase_fail: assert property (p_erase_fail) else $error("unsecure after failed erase");
  property p_reg_we_halted; cpu_reg_we |-> cpu_halt; endproperty
  a_reg_we_halted: assert property (p_reg_we_halted) else $error("register write running");
endmodule // debug_access_asserts

bind debug_access_ctrl debug_access_asserts #(.TIMEOUT(TIMEOUT)) u_debug_access_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .cpu_halt,
  .cpu_reg_we, .bus_free, .bus_req, .bus_steal, .erase_req, .erase_done, .erase_ok,
  .unsecured_flag_program
);

// >>> tb/testbench.sv
// Self-checking bench for the debug access controller over APB.
// Assumes the core side model and the bound port checker.
`timescale 1ns/1ns
module testbench;
  import debug_access_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, cpu_reg_rdata, cpu_reg_wdata, bus_rdata;
  logic secure_strap = 1'b1, ssc_strap = 1'b0, nvm_init_busy = 1'b0, breakpoint_hit = 1'b0;
  logic halt_insn = 1'b0, slow = 1'b0, erase_pass = 1'b0;
  logic pready, pslverr, cpu_halt, cpu_step, cpu_reg_we, bus_free, bus_steal;
  logic erase_done, erase_ok, erase_req, unsecured_flag_program, clk_sel, ack_pulse, ack_long, sync_pulse;
  logic [3:0] cpu_reg_num;
  bus_req_s bus_req;
  logic [33:0] exp_q [$];
  logic [31:0] seed_q = 32'h0000003A;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [3:0] pulse_q = 4'h0;

  always #5 pclk = ~pclk;
  // Sticky record of one-cycle strobes
  always @(posedge pclk) pulse_q <= pulse_q | {ack_long, ack_pulse, cpu_step, sync_pulse};

  debug_access_ctrl #(.TIMEOUT(8)) u_debug_access_ctrl (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .secure_strap, .ssc_strap,
    .nvm_init_busy, .halt_insn, .breakpoint_hit, .cpu_reg_rdata, .cpu_halt, .cpu_step,
    .cpu_reg_we, .cpu_reg_num, .cpu_reg_wdata, .bus_free, .bus_rdata, .bus_req, .bus_steal,
    .erase_done, .erase_ok, .erase_req, .unsecured_flag_program, .clk_sel, .ack_pulse, .ack_long,
    .sync_pulse);
  core_side_model u_core_side_model (.pclk, .presetn, .slow, .erase_pass, .bus_req,
    .erase_req, .cpu_reg_we, .cpu_reg_num, .cpu_reg_wdata, .bus_free, .bus_rdata,
    .erase_done, .erase_ok, .cpu_reg_rdata);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One transfer; e holds {compare data, expected error, expected data}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e, output logic [31:0] r);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, {2'b10, want}, r);
  endtask
  // Address and data first, then the opcode; poll until idle, then the host gap
  task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input logic [31:0] wd);
    logic [31:0] r;
    apb(1'b1, OFF_ADDR, ad, 34'h000000000, r);
    apb(1'b1, OFF_WDATA, wd, 34'h000000000, r);
    apb(1'b1, OFF_CMD, {24'h000000, op}, 34'h000000000, r);
    do apb(1'b0, OFF_CMD, 32'h00000000, 34'h000000000, r); while (r[B_BUSY] !== 1'b0);
    repeat (16) @(posedge pclk);
  endtask

  // Result watcher: oldest note against each completed transfer
  always @(posedge pclk) begin : watch
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h00000000, 32'h00000001);
      else begin
        e = exp_q.pop_front();
        chk({31'h00000000, pslverr}, {31'h00000000, e[32]});
        if (!pwrite && e[33]) chk(prdata, e[31:0]);
      end
    end
  end

  initial begin : watchdog
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin : main
    logic [31:0] r;
    logic [31:0] wd;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmd(OP_MEM_RD, 32'h00000000, 32'h00000000);
    rd(OFF_RDATA, ILLEGAL_DATA);
    rd(OFF_CSR, 32'h00000001);
    cmd(OP_HALT, 32'h00000000, 32'h00000000);
    chk({31'h00000000, cpu_halt}, 32'h00000000);
    cmd(OP_ERASE, 32'h00000000, 32'h00000000);
    rd(OFF_CSR, 32'h00000001);
    erase_pass <= 1'b1;
    cmd(OP_ERASE, 32'h00000000, 32'h00000000);
    rd(OFF_CSR, 32'h00000081);
    cmd(OP_CSR_WR, 32'h00000000, 32'h00000049);
    chk({31'h00000000, clk_sel}, 32'h00000001);
    repeat (150) @(posedge pclk);
    cmd(OP_SYNC, 32'h00000000, 32'h00000000);
    chk({28'h0000000, pulse_q}, 32'h00000001);
    rd(OFF_CSR, 32'h000000C8);
    cmd(OP_HALT, 32'h00000000, 32'h00000000);
    chk({31'h00000000, cpu_halt}, 32'h00000001);
    seed_q = lfsr(seed_q);
    cmd(OP_MEM_RD, {8'h00, seed_q[23:0]}, 32'h00000000);
    rd(OFF_RDATA, {8'h5A, seed_q[23:0]});
    seed_q = lfsr(seed_q);
    wd = seed_q;
    cmd(OP_REG_WR, 32'h00000003, wd);
    cmd(OP_REG_RD, 32'h00000003, 32'h00000000);
    rd(OFF_RDATA, wd);
    cmd(OP_STEP, 32'h00000000, 32'h00000000);
    chk({28'h0000000, pulse_q}, 32'h00000003);
    cmd(OP_RESUME, 32'h00000000, 32'h00000000);
    chk({31'h00000000, cpu_halt}, 32'h00000000);
    cmd(OP_REG_RD, 32'h00000003, 32'h00000000);
    rd(OFF_CSR, 32'h000000C9);
    halt_insn <= 1'b1;
    @(posedge pclk);
    halt_insn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h00000000, cpu_halt}, 32'h00000001);
    cmd(OP_RESUME, 32'h00000000, 32'h00000000);
    breakpoint_hit <= 1'b1;
    @(posedge pclk);
    breakpoint_hit <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h00000000, cpu_halt}, 32'h00000001);
    cmd(OP_RESUME, 32'h00000000, 32'h00000000);
    cmd(OP_ACK_EN, 32'h00000000, 32'h00000000);
    slow <= 1'b1;
    cmd(OP_MEM_RD, 32'h00000040, 32'h00000000);
    rd(OFF_RDATA, ILLEGAL_DATA);
    rd(OFF_CSR, 32'h000000CF);
    chk({28'h0000000, pulse_q}, 32'h0000000F);
    apb(1'b0, 8'h20, 32'h00000000, {2'b01, 32'h00000000}, r);
    apb(1'b1, OFF_CSR, 32'h000000FF, {2'b01, 32'h00000000}, r);
    rd(OFF_CSR, 32'h000000CF);
    // Second reset, open and single-chip; the first command stalls until ready
    presetn <= 1'b0;
    secure_strap <= 1'b0;
    ssc_strap <= 1'b1;
    nvm_init_busy <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, OFF_CMD, {24'h000000, OP_CSR_RD}, 34'h000000000, r);
    rd(OFF_RDATA, 32'h000000A0);
    apb(1'b1, OFF_CMD, {24'h000000, OP_NOP}, 34'h000000000, r);
    rd(OFF_CMD, 32'h00000300);
    nvm_init_busy <= 1'b0;
    rd(OFF_CSR, 32'h000000A1);
    give_verdict();
  end
endmodule // testbench
